// >>> core/sbrg_pkg.sv
// constants and helpers for the serial baud rate generator
package sbrg_pkg;

    // ************************************************************
    // register byte addresses on the cpu register port
    // ************************************************************
    localparam logic [7:0] ADDR_STATUS  = 8'h50; // serial_status, read only
    localparam logic [7:0] ADDR_DATA    = 8'h51; // serial_data
    localparam logic [7:0] ADDR_DIVSEL  = 8'h52; // baud_divisor_select
    localparam logic [7:0] ADDR_CTL_ONE = 8'h53; // frame_control_one
    localparam logic [7:0] ADDR_CTL_TWO = 8'h54; // frame_control_two
    localparam logic [7:0] ADDR_RX_FINE = 8'h55; // receive_fine_prescaler
    localparam logic [7:0] ADDR_TX_FINE = 8'h57; // transmit_fine_prescaler

    // ************************************************************
    // field positions inside baud_divisor_select
    // ************************************************************
    localparam int PRESCALE_MSB = 7; // first_prescale_code
    localparam int PRESCALE_LSB = 6;
    localparam int TX_CODE_MSB  = 5; // transmit_divisor_code
    localparam int TX_CODE_LSB  = 3;
    localparam int RX_CODE_MSB  = 2; // receive_divisor_code
    localparam int RX_CODE_LSB  = 0;

    // ************************************************************
    // reset values and fixed masks
    // ************************************************************
    localparam logic [7:0] DIVSEL_RESET = 8'h00;
    localparam logic [7:0] CTL_ONE_RESET = 8'h00;
    localparam logic [7:0] CTL_TWO_RESET = 8'h00;
    localparam logic [7:0] FINE_RESET   = 8'h00; // fine prescaler off
    localparam logic [7:0] STATUS_MASK  = 8'hFE; // bit 0 unused, reads 0
    localparam logic [7:0] OVERSAMPLE_DIV = 8'h10; // fixed divide by 16

    // first_prescale_factor for each first_prescale_code
    function automatic logic [7:0] sbrg_prescale_factor(input logic [1:0] code);
        logic [7:0] factor;
        case (code)
            2'h0:    factor = 8'h01;
            2'h1:    factor = 8'h03;
            2'h2:    factor = 8'h04;
            default: factor = 8'h0D;
        endcase
        return factor;
    endfunction

endpackage

// >>> core/sbrg_divider.sv
// divide-by-n enable divider, counts qualifying enable pulses
`timescale 1ns/1ps

module sbrg_divider #(
    parameter int WIDTH = 8 // counter and divisor width
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset,
    input  wire logic             i_en,      // one input tick
    input  wire logic [WIDTH-1:0] i_divisor, // n, zero acts as one
    output logic                  o_pulse    // one tick per n input ticks
);

    // ************************************************************
    // wrap detection
    // ************************************************************
    logic [WIDTH-1:0] count_q; // ticks seen in this period
    logic             last;    // this tick closes the period

    // >= rather than == so a shrunken divisor recovers at once
    assign last = (i_divisor <= WIDTH'(1))
               || (count_q >= i_divisor - WIDTH'(1));

    assign o_pulse = i_en && last;

    // ************************************************************
    // tick counter
    // ************************************************************
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            count_q <= '0;
        end
        else if (i_en)
        begin
            // restart on wrap, else count
            count_q <= last ? '0 : count_q + WIDTH'(1);
        end
    end

endmodule

// >>> core/sbrg_pow2_div.sv
// power-of-two enable divider selected by a three-bit code
`timescale 1ns/1ps

module sbrg_pow2_div (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_en,   // one input tick
    input  wire logic [2:0] i_code, // divide by 2 to the power code
    output logic            o_pulse // one tick per 2**code input ticks
);

    // ************************************************************
    // free running count, decoded by mask
    // ************************************************************
    logic [6:0] count_q; // ticks seen, wraps at 128
    logic [6:0] mask;    // low bits that must all be ones

    // a free binary counter keeps every code in step at no extra cost
    assign mask    = 7'((8'h01 << i_code) - 8'h01);
    assign o_pulse = i_en && (&(count_q | ~mask));

    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            count_q <= 7'h00;
        end
        else if (i_en)
        begin
            count_q <= count_q + 7'h01;
        end
    end

endmodule

// >>> core/sbrg_top.sv
// baud rate generator and register file of the serial interface
`timescale 1ns/1ps

module sbrg_top (
    input  wire logic       i_clk,               // bus clock, 10 MHz
    input  wire logic       i_reset,             // synchronous, active high
    input  wire logic [7:0] i_addr,              // cpu register address
    input  wire logic       i_wr,                // cpu write strobe
    input  wire logic       i_rd,                // cpu read strobe
    input  wire logic [7:0] i_wdata,             // cpu write data
    input  wire logic [7:0] i_serial_status,     // flags from shift logic
    input  wire logic       i_rx_load,           // shift logic delivers a word
    input  wire logic [7:0] i_rx_data,           // received word
    output logic      [7:0] o_rdata,             // cpu read data
    output logic      [7:0] o_transmit_holding,  // word for the shifter
    output logic            o_tx_load,           // transmit_holding written
    output logic            o_rx_read,           // receive_holding read
    output logic      [7:0] o_frame_control_one, // framing control
    output logic      [7:0] o_frame_control_two, // enables and modes
    output logic            o_tx_rate_en,        // transmit rate tick
    output logic            o_rx_rate_en         // receive rate tick
);

    // ************************************************************
    // register storage
    // ************************************************************
    logic [7:0] divsel_q;  // baud_divisor_select
    logic [7:0] ctl_one_q; // frame_control_one
    logic [7:0] ctl_two_q; // frame_control_two
    logic [7:0] rx_fine_q; // receive_fine_prescale
    logic [7:0] tx_fine_q; // transmit_fine_prescale
    logic [7:0] tx_hold_q; // transmit_holding
    logic [7:0] rx_hold_q; // receive_holding
    logic [7:0] rdata_q;   // registered read data
    logic       tx_load_q; // write pulse toward shifter
    logic       rx_read_q; // read pulse toward shifter
    logic       tx_rate_q; // selected transmit tick
    logic       rx_rate_q; // selected receive tick

    // decoded strobes
    logic wr_divsel;
    logic wr_rx_fine;
    logic wr_tx_fine;
    logic wr_data;
    logic rd_data;

    assign wr_divsel  = i_wr && (i_addr == sbrg_pkg::ADDR_DIVSEL);
    assign wr_rx_fine = i_wr && (i_addr == sbrg_pkg::ADDR_RX_FINE);
    assign wr_tx_fine = i_wr && (i_addr == sbrg_pkg::ADDR_TX_FINE);
    assign wr_data    = i_wr && (i_addr == sbrg_pkg::ADDR_DATA);
    assign rd_data    = i_rd && (i_addr == sbrg_pkg::ADDR_DATA);

    // field views of baud_divisor_select
    logic [1:0] first_prescale_code;
    logic [2:0] transmit_divisor_code;
    logic [2:0] receive_divisor_code;
    logic [7:0] first_prescale_factor;

    assign first_prescale_code =
        divsel_q[sbrg_pkg::PRESCALE_MSB:sbrg_pkg::PRESCALE_LSB];
    assign transmit_divisor_code =
        divsel_q[sbrg_pkg::TX_CODE_MSB:sbrg_pkg::TX_CODE_LSB];
    assign receive_divisor_code =
        divsel_q[sbrg_pkg::RX_CODE_MSB:sbrg_pkg::RX_CODE_LSB];
    assign first_prescale_factor =
        sbrg_pkg::sbrg_prescale_factor(first_prescale_code);

    // ************************************************************
    // register writes
    // ************************************************************
    // configuration registers, written only by the cpu
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            divsel_q  <= sbrg_pkg::DIVSEL_RESET;
            ctl_one_q <= sbrg_pkg::CTL_ONE_RESET;
            ctl_two_q <= sbrg_pkg::CTL_TWO_RESET;
            rx_fine_q <= sbrg_pkg::FINE_RESET;
            tx_fine_q <= sbrg_pkg::FINE_RESET;
        end
        else if (i_wr)
        begin
            if (i_addr == sbrg_pkg::ADDR_DIVSEL)
            begin
                divsel_q <= i_wdata;
            end
            else if (i_addr == sbrg_pkg::ADDR_CTL_ONE)
            begin
                ctl_one_q <= i_wdata;
            end
            else if (i_addr == sbrg_pkg::ADDR_CTL_TWO)
            begin
                ctl_two_q <= i_wdata;
            end
            else if (i_addr == sbrg_pkg::ADDR_RX_FINE)
            begin
                rx_fine_q <= i_wdata;
            end
            else if (i_addr == sbrg_pkg::ADDR_TX_FINE)
            begin
                tx_fine_q <= i_wdata;
            end
        end
    end

    // transmit side of the data address
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            tx_hold_q <= 8'h00;
            tx_load_q <= 1'b0;
        end
        else
        begin
            if (wr_data)
            begin
                tx_hold_q <= i_wdata;
            end
            tx_load_q <= wr_data;
        end
    end

    // receive side, filled only by the shift logic
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            rx_hold_q <= 8'h00;
        end
        else if (i_rx_load)
        begin
            rx_hold_q <= i_rx_data;
        end
    end

    // ************************************************************
    // register reads
    // ************************************************************
    // data appears one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            rdata_q   <= 8'h00;
            rx_read_q <= 1'b0;
        end
        else
        begin
            rx_read_q <= rd_data;
            if (!i_rd)
            begin
                rdata_q <= 8'h00;
            end
            else if (i_addr == sbrg_pkg::ADDR_STATUS)
            begin
                rdata_q <= i_serial_status & sbrg_pkg::STATUS_MASK;
            end
            else if (i_addr == sbrg_pkg::ADDR_DATA)
            begin
                rdata_q <= rx_hold_q;
            end
            else if (i_addr == sbrg_pkg::ADDR_DIVSEL)
            begin
                rdata_q <= divsel_q;
            end
            else if (i_addr == sbrg_pkg::ADDR_CTL_ONE)
            begin
                rdata_q <= ctl_one_q;
            end
            else if (i_addr == sbrg_pkg::ADDR_CTL_TWO)
            begin
                rdata_q <= ctl_two_q;
            end
            else if (i_addr == sbrg_pkg::ADDR_RX_FINE)
            begin
                rdata_q <= rx_fine_q;
            end
            else if (i_addr == sbrg_pkg::ADDR_TX_FINE)
            begin
                rdata_q <= tx_fine_q;
            end
            else
            begin
                rdata_q <= 8'h00;
            end
        end
    end

    // ************************************************************
    // conventional divider chain
    // ************************************************************
    logic pr_en;    // bus clock over first_prescale_factor
    logic conv16_en; // further over 16
    logic conv_tx;  // conventional transmit tick
    logic conv_rx;  // conventional receive tick

    sbrg_divider #(.WIDTH(8)) u_first_prescale (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_en      (1'b1),
        .i_divisor (first_prescale_factor),
        .o_pulse   (pr_en)
    );

    // fixed divide by 16 before the divisors
    sbrg_divider #(.WIDTH(8)) u_conv_sixteen (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_en      (pr_en),
        .i_divisor (sbrg_pkg::OVERSAMPLE_DIV),
        .o_pulse   (conv16_en)
    );

    sbrg_pow2_div u_tx_pow2 (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_en    (conv16_en),
        .i_code  (transmit_divisor_code),
        .o_pulse (conv_tx)
    );

    sbrg_pow2_div u_rx_pow2 (
        .i_clk   (i_clk),
        .i_reset (i_reset),
        .i_en    (conv16_en),
        .i_code  (receive_divisor_code),
        .o_pulse (conv_rx)
    );

    // ************************************************************
    // extended (fine) divider chain
    // ************************************************************
    logic ext16_en; // bus clock over 16, feeds both fine dividers
    logic ext_tx;   // fine transmit tick
    logic ext_rx;   // fine receive tick

    sbrg_divider #(.WIDTH(8)) u_ext_sixteen (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_en      (1'b1),
        .i_divisor (sbrg_pkg::OVERSAMPLE_DIV),
        .o_pulse   (ext16_en)
    );

    sbrg_divider #(.WIDTH(8)) u_tx_fine (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_en      (ext16_en),
        .i_divisor (tx_fine_q),
        .o_pulse   (ext_tx)
    );

    sbrg_divider #(.WIDTH(8)) u_rx_fine (
        .i_clk     (i_clk),
        .i_reset   (i_reset),
        .i_en      (ext16_en),
        .i_divisor (rx_fine_q),
        .o_pulse   (ext_rx)
    );

    // ************************************************************
    // rate selection
    // ************************************************************
    // registered so the rate ticks are glitch free outputs
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            tx_rate_q <= 1'b0;
            rx_rate_q <= 1'b0;
        end
        else
        begin
            tx_rate_q <= (tx_fine_q != 8'h00) ? ext_tx : conv_tx;
            rx_rate_q <= (rx_fine_q != 8'h00) ? ext_rx : conv_rx;
        end
    end

    assign o_rdata             = rdata_q;
    assign o_transmit_holding  = tx_hold_q;
    assign o_tx_load           = tx_load_q;
    assign o_rx_read           = rx_read_q;
    assign o_frame_control_one = ctl_one_q;
    assign o_frame_control_two = ctl_two_q;
    assign o_tx_rate_en        = tx_rate_q;
    assign o_rx_rate_en        = rx_rate_q;

    // ************************************************************
    // checks: tick spacing helpers
    // ************************************************************
    // per tick stream: cycles since last tick, valid after one full period
    logic [2:0]  tick_vec;
    logic [15:0] gap_q [3];
    logic [2:0]  gap_ok_q;
    logic        cfg_wr_q; // rate setting written last cycle

    assign tick_vec = {o_rx_rate_en, o_tx_rate_en, pr_en};

    // cleared one cycle late: the registered tick still in flight from
    // the old setting must not arm the spacing checks
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            cfg_wr_q <= 1'b0;
        end
        else
        begin
            cfg_wr_q <= wr_divsel || wr_rx_fine || wr_tx_fine;
        end
    end

    for (genvar g = 0; g < 3; g++)
    begin : g_gap
        always_ff @(posedge i_clk)
        begin
            if (i_reset || cfg_wr_q)
            begin
                gap_q[g]    <= 16'h0000;
                gap_ok_q[g] <= 1'b0;
            end
            else if (tick_vec[g])
            begin
                gap_q[g]    <= 16'h0000;
                gap_ok_q[g] <= 1'b1;
            end
            else if (gap_q[g] != 16'hFFFF)
            begin
                gap_q[g] <= gap_q[g] + 16'h0001;
            end
        end
    end

    prescale_spacing_a: assert property (@(posedge i_clk) disable iff (i_reset)
        pr_en && gap_ok_q[0] |-> gap_q[0] == 16'(first_prescale_factor - 8'h01))
        else $error("first prescaler tick spacing wrong");

    tx_conv_spacing_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_tx_rate_en && gap_ok_q[1] && tx_fine_q == 8'h00 |->
        gap_q[1] == 16'(16 * first_prescale_factor * (1 << transmit_divisor_code) - 1))
        else $error("conventional transmit rate spacing wrong");

    // receive tick follows the conventional chain
    rx_conv_source_a: assert property (@(posedge i_clk) disable iff (i_reset)
        rx_fine_q == 8'h00 |=> o_rx_rate_en == $past(conv_rx))
        else $error("receive rate not from conventional divisor");

    // transmit tick follows the fine chain
    tx_fine_source_a: assert property (@(posedge i_clk) disable iff (i_reset)
        tx_fine_q != 8'h00 |=> o_tx_rate_en == $past(ext_tx))
        else $error("transmit rate not from fine prescaler");

    // receive tick follows the fine chain
    rx_fine_source_a: assert property (@(posedge i_clk) disable iff (i_reset)
        rx_fine_q != 8'h00 |=> o_rx_rate_en == $past(ext_rx))
        else $error("receive rate not from fine prescaler");

    // fine receive spacing is 16 times N
    rx_fine_spacing_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_rx_rate_en && gap_ok_q[2] && rx_fine_q != 8'h00 |->
        gap_q[2] == 16'(16 * rx_fine_q - 1))
        else $error("fine receive rate spacing wrong");

    // fine transmit spacing is 16 times N
    tx_fine_spacing_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_tx_rate_en && gap_ok_q[1] && tx_fine_q != 8'h00 |->
        gap_q[1] == 16'(16 * tx_fine_q - 1))
        else $error("fine transmit rate spacing wrong");

    fine_reset_a: assert property (@(posedge i_clk) disable iff (i_reset)
        $fell(i_reset) |-> rx_fine_q == 8'h00 && tx_fine_q == 8'h00)
        else $error("fine prescalers not cleared by reset");

    // data write loads transmit holding only
    data_write_a: assert property (@(posedge i_clk) disable iff (i_reset)
        wr_data && !i_rx_load |=> o_tx_load && o_transmit_holding == $past(i_wdata)
        && $stable(rx_hold_q))
        else $error("data write did not load transmit holding");

    data_read_a: assert property (@(posedge i_clk) disable iff (i_reset)
        rd_data |=> o_rx_read && o_rdata == $past(rx_hold_q))
        else $error("data read did not return receive holding");

    rx_conv_spacing_a: assert property (@(posedge i_clk) disable iff (i_reset)
        o_rx_rate_en && gap_ok_q[2] && rx_fine_q == 8'h00 |->
        gap_q[2] == 16'(16 * first_prescale_factor * (1 << receive_divisor_code) - 1))
        else $error("conventional receive rate spacing wrong");

    conv_tx_c: cover property (@(posedge i_clk) disable iff (i_reset)
        o_tx_rate_en && gap_ok_q[1] && tx_fine_q == 8'h00);
    fine_rx_c: cover property (@(posedge i_clk) disable iff (i_reset)
        o_rx_rate_en && gap_ok_q[2] && rx_fine_q != 8'h00);
    data_write_c: cover property (@(posedge i_clk) disable iff (i_reset) wr_data);
    data_read_c: cover property (@(posedge i_clk) disable iff (i_reset) rd_data);

endmodule

// >>> sim/sbrg_shift_model.sv
// behavioural shift logic that loops the latest transmitted word back, plus 0x11, as received
`timescale 1ns/1ps

module sbrg_shift_model (
    input  wire logic       i_clk,
    input  wire logic       i_reset,
    input  wire logic       i_tx_load,          // new transmit word
    input  wire logic [7:0] i_transmit_holding, // word to send
    input  wire logic       i_rx_read,          // cpu took the word
    output logic            o_rx_load,          // delivery pulse
    output logic      [7:0] o_rx_data,          // received word
    output logic      [7:0] o_serial_status     // flags for 0x50
);
    logic [7:0] word_q; // word in flight, offset so it differs from tx
    logic [3:0] cnt_q;  // frame time left
    logic       busy_q; // frame in flight
    logic       rdy_q;  // received word waiting
    // ************************************************************
    // loopback frame
    // ************************************************************
    // separate holding words
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            busy_q    <= 1'b0;
            rdy_q     <= 1'b0;
            cnt_q     <= 4'h0;
            o_rx_load <= 1'b0;
        end
        else
        begin
            o_rx_load <= 1'b0;
            if (i_tx_load)
            begin
                busy_q <= 1'b1;
                cnt_q  <= 4'hA;
                word_q <= i_transmit_holding + 8'h11;
            end
            else if (busy_q)
            begin
                cnt_q <= cnt_q - 4'h1;
                if (cnt_q == 4'h1)
                begin
                    busy_q    <= 1'b0;
                    rdy_q     <= 1'b1;
                    o_rx_load <= 1'b1;
                end
            end
            if (i_rx_read)
                rdy_q <= 1'b0;
        end
    end
    // data is only valid with the pulse; inverse otherwise to expose misuse
    assign o_rx_data       = o_rx_load ? word_q : ~word_q;
    // bit 0 driven high on purpose: the block must force it low
    assign o_serial_status = {~busy_q, 1'b0, rdy_q, 4'h0, 1'b1};
endmodule

// >>> sim/tb_sbrg_top.sv
// self-checking bench for the baud rate generator and its registers
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED at %0t: got %h want %h", $time, a, e); end end

module tb_sbrg_top;
    typedef struct {logic [7:0] dv, rf, tf; logic [15:0] tp, rp;} sbrg_row_type;
    logic i_clk, i_reset, i_wr, i_rd, i_rx_load, o_tx_load, o_rx_read, tx_en, rx_en;
    logic [7:0] i_addr, i_wdata, i_st, i_rxd, o_rdata, o_th, o_c1, o_c2, d;
    logic [15:0] n;
    int bad_count, comparisons;
    realtime rel_t = -1.0; // time at which the last strobe was lowered
    // divisor select, rx fine, tx fine, tx period, rx period
    sbrg_row_type rows [6] = '{
        '{8'h00, 8'h00, 8'h00, 16'd16, 16'd16},
        '{8'h4A, 8'h00, 8'h00, 16'd96, 16'd192},
        '{8'h80, 8'h00, 8'h00, 16'd64, 16'd64},
        '{8'hDC, 8'h00, 8'h00, 16'd1664, 16'd3328},
        '{8'h38, 8'h00, 8'h00, 16'd2048, 16'd16},
        '{8'hDF, 8'h03, 8'hFF, 16'd4080, 16'd48}};

    sbrg_top i_sbrg_top (.i_clk(i_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wr(i_wr),
        .i_rd(i_rd), .i_wdata(i_wdata), .i_serial_status(i_st), .i_rx_load(i_rx_load),
        .i_rx_data(i_rxd), .o_rdata(o_rdata), .o_transmit_holding(o_th),
        .o_tx_load(o_tx_load), .o_rx_read(o_rx_read), .o_frame_control_one(o_c1),
        .o_frame_control_two(o_c2), .o_tx_rate_en(tx_en), .o_rx_rate_en(rx_en));
    sbrg_shift_model i_sbrg_shift_model (.i_clk(i_clk), .i_reset(i_reset),
        .i_tx_load(o_tx_load), .i_transmit_holding(o_th), .i_rx_read(o_rx_read),
        .o_rx_load(i_rx_load), .o_rx_data(i_rxd), .o_serial_status(i_st));

    initial
    begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    // ************************************************************
    // register port and tick measurement
    // ************************************************************
    // a strobe lowered in this time step gets one idle edge first
    task automatic idle();
        if ($realtime == rel_t)
        begin
            @(posedge i_clk);
            #10;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        idle();
        {i_wr, i_addr, i_wdata} = {1'b1, a, v};
        @(posedge i_clk); #10;
        i_wr = 1'b0;
        rel_t = $realtime;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        idle();
        {i_rd, i_addr} = {1'b1, a};
        @(posedge i_clk); #10;
        i_rd = 1'b0;
        rel_t = $realtime;
        v = o_rdata;
    endtask
    // two ticks skipped so a config change cannot skew the period
    task automatic meas(input bit tx, output logic [15:0] p);
        for (int k = 0; k < 3; k++)
        begin
            p = 16'h0;
            do begin @(posedge i_clk); #10; p++; end
            while (((tx ? tx_en : rx_en) !== 1'b1) && p < 16'hFFFF);
        end
    endtask
    task automatic results();
        if (bad_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #7_000_000;
        bad_count++;
        results();
    end

    initial
    begin
        {i_reset, i_wr, i_rd, i_addr, i_wdata} = {3'b100, 16'h0000};
        repeat (2) @(posedge i_clk);
        #10 i_reset = 1'b0;
        rd(sbrg_pkg::ADDR_RX_FINE, d); `CHK(d, 8'h00)
        rd(sbrg_pkg::ADDR_TX_FINE, d); `CHK(d, 8'h00)
        foreach (rows[i])
        begin
            wr(sbrg_pkg::ADDR_RX_FINE, rows[i].rf);
            wr(sbrg_pkg::ADDR_TX_FINE, rows[i].tf);
            wr(sbrg_pkg::ADDR_DIVSEL, rows[i].dv);
            meas(1'b1, n); `CHK(n, rows[i].tp)
            meas(1'b0, n); `CHK(n, rows[i].rp)
        end
        rd(sbrg_pkg::ADDR_DIVSEL, d); `CHK(d, 8'hDF)
        // data address: write path and read path stay apart
        wr(sbrg_pkg::ADDR_DATA, 8'hA5); `CHK({o_tx_load, o_th}, 9'h1A5)
        wr(sbrg_pkg::ADDR_CTL_ONE, 8'h5A); `CHK(o_c1, 8'h5A)
        wr(8'h56, 8'hFF); `CHK(o_tx_load, 1'b0)
        wr(sbrg_pkg::ADDR_CTL_TWO, 8'hC3); `CHK(o_c2, 8'hC3)
        rd(8'h56, d); `CHK(d, 8'h00)
        repeat (20) @(posedge i_clk);
        #10;
        rd(sbrg_pkg::ADDR_STATUS, d); `CHK(d, 8'hA0)
        rd(sbrg_pkg::ADDR_DATA, d); `CHK({o_rx_read, d}, 9'h1B6)
        rd(sbrg_pkg::ADDR_STATUS, d); `CHK(d, 8'h80)
        // second reset in mid-run falls back to the conventional path
        i_reset = 1'b1;
        @(posedge i_clk); #10;
        i_reset = 1'b0;
        rd(sbrg_pkg::ADDR_TX_FINE, d); `CHK(d, 8'h00)
        meas(1'b0, n); `CHK(n, 16'd16)
        meas(1'b1, n); `CHK(n, 16'd16)
        results();
    end
endmodule
